// ==== adc_sweep_pkg.sv ====
package adc_sweep_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_CTRL1    = 8'h04;
  localparam logic [7:0] OFS_CTRL2    = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_RESULT   = 8'h20;

  // converter_control_0 fields
  localparam int C0_CHAN_LSB  = 0;
  localparam int C0_MODE_LSB  = 3;
  localparam int C0_TRIG      = 5;
  localparam int C0_START     = 6;
  localparam int C0_DIV0      = 7;

  // converter_control_1 fields
  localparam int C1_WIDTH_LSB = 0;
  localparam int C1_SWEEP1    = 2;
  localparam int C1_TEN_BIT   = 3;
  localparam int C1_DIV1      = 4;
  localparam int C1_REF       = 5;
  localparam int C1_OPAMP_LSB = 6;

  // converter_control_2 fields
  localparam int C2_SH        = 0;
  localparam int C2_GROUP_LSB = 1;
  localparam int C2_DIV2      = 3;
  localparam logic [7:0] CTRL2_MASK = 8'h0f;

  // reset values
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;

  // converter clock cycles per pin
  localparam int CONV_SH_8    = 28;
  localparam int CONV_SH_10   = 33;
  localparam int CONV_NOSH_8  = 49;
  localparam int CONV_NOSH_10 = 59;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT     = 2'b00,
    MODE_REPEAT       = 2'b01,
    MODE_SINGLE_SWEEP = 2'b10,
    MODE_REPEAT_SWEEP = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    ROUTE_NONE  = 2'b00,
    ROUTE_EXT_A = 2'b01,
    ROUTE_EXT_B = 2'b10,
    ROUTE_LOOP  = 2'b11
  } opamp_route_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WAIT_TRIG = 2'b01,
    ST_CONVERT   = 2'b10
  } seq_state_t;

  // converter clock divide ratio from the three select bits
  function automatic logic [3:0] div_ratio(input logic [2:0] sel);
    case (sel)
      3'h0:    div_ratio = 4'h4;
      3'h1:    div_ratio = 4'h2;
      3'h4:    div_ratio = 4'hc;
      3'h5:    div_ratio = 4'h6;
      3'h6,
      3'h7:    div_ratio = 4'h3;
      default: div_ratio = 4'h1;
    endcase
  endfunction

  // converter clock cycles for one pin
  function automatic logic [5:0] conv_cycles(input logic sh,
                                             input logic ten);
    if (sh) begin
      conv_cycles = ten ? 6'(CONV_SH_10) : 6'(CONV_SH_8);
    end else begin
      conv_cycles = ten ? 6'(CONV_NOSH_10) : 6'(CONV_NOSH_8);
    end
  endfunction

  // first non-priority pin in repeat sweep 1
  function automatic logic [2:0] first_other(input logic [1:0] w);
    first_other = {1'b0, w} + 3'h1;
  endfunction

endpackage

// ==== conv_timer_if.sv ====
interface conv_timer_if;
  logic [2:0] div_sel;
  logic       sh_en;
  logic       ten_bit;
  logic       go;
  logic       clear;
  logic       done;

  modport seq   (output div_sel, sh_en, ten_bit, go, clear, input done);
  modport timer (input div_sel, sh_en, ten_bit, go, clear, output done);
endinterface

// ==== conv_timer.sv ====
module conv_timer (
  input wire logic    core_clk,
  input wire logic    rst,
  conv_timer_if.timer tm
);

  logic [3:0] div_cnt_q;
  logic [5:0] tick_cnt_q;
  logic       done_q;

  // converter clock enable and per-pin cycle target
  wire [3:0] ratio_w  = adc_sweep_pkg::div_ratio(tm.div_sel);
  wire       tick_w   = (div_cnt_q >= ratio_w - 4'h1);
  wire [5:0] target_w = adc_sweep_pkg::conv_cycles(tm.sh_en, tm.ten_bit);
  wire       last_w   = tick_w && (tick_cnt_q >= target_w - 6'h01);
  wire       run_w    = tm.go && !tm.clear;

  // divider and pin timer, restart on their own while go holds
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q  <= 4'h0;
      tick_cnt_q <= 6'h00;
      done_q     <= 1'b0;
    end else if (!run_w) begin
      div_cnt_q  <= 4'h0;
      tick_cnt_q <= 6'h00;
      done_q     <= 1'b0;
    end else begin
      div_cnt_q  <= tick_w ? 4'h0 : div_cnt_q + 4'h1; // see R19
      if (tick_w) begin
        tick_cnt_q <= last_w ? 6'h00 : tick_cnt_q + 6'h01; // see R13
      end
      done_q     <= last_w;
    end
  end

  assign tm.done = done_q;

  ////////////////////////////////////////////////////////////////////////
  property p_pin_len;
    @(posedge core_clk) disable iff (rst)
    (run_w && last_w) |=> tm.done;
  endproperty
  a_pin_len: assert property (p_pin_len) // see R13
    else $error("pin conversion did not end at cycle target");

  property p_done_gap;
    @(posedge core_clk) disable iff (rst)
    tm.done |=> !tm.done [*8];
  endproperty
  a_done_gap: assert property (p_done_gap) // see R13
    else $error("pin conversions closer than minimum length");

endmodule

// ==== adc_sweep_sequencer.sv ====
// Operation
// R01 - single sweep converts each selected pin once, in order, then ends
// R02 - trigger select 0: start as soon as start bit is written 1
// R03 - trigger select 1: falling trigger pin edge after start bit; retriggers
// R04 - single sweep stops at end; soft trigger clears start; 0 halts
// R05 - interrupt request at single sweep end, none in repeat sweeps
// R06 - sweep width picks first two, four, six or eight pins
// R07 - repeat sweep 0 loops over selected pins until start cleared
// R08 - repeat sweep 1 converts all eight pins, priority pins interleaved
// R09 - in repeat sweep 1 width selects priority pins 0 to 0..3
// R10 - each result lands in the result register of its pin position
// R11 - input group field picks one of three eight-pin groups
// R12 - resolution 1 gives 10-bit result, 0 gives 8-bit result
// R13 - with sample-hold a pin takes 28 or 33 converter cycles
// R14 - sample-hold applies in all modes; software picks it before start
// R15 - software must not rewrite control registers during conversion
// R16 - software waits 1 us after connecting reference before start
// R17 - one-shot and repeat may convert extended pins into results 0 and 1
// R18 - op-amp loop routes pin out and converts returned signal
// R19 - converter clock is divided by 1, 2, 3, 4, 6 or 12
// R20 - start refused unless reference already connected; no disconnect
// R21 - next pin selected right after storing each result
// R22 - start bit stays 1 through repeat sweeps until software clears it
//
// Added by the designer: the register offsets and the Wishbone register port.
module adc_sweep_sequencer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        external_trigger_pin,
  input  wire logic [9:0]  afe_code,
  output logic             conv_irq,
  output logic      [1:0]  afe_group,
  output logic      [2:0]  afe_channel,
  output logic      [1:0]  afe_route,
  output logic             afe_ten_bit,
  output logic             afe_sample_hold,
  output logic             afe_ref_connect,
  output logic             afe_active
);

  logic [7:0]               ctrl0_q;
  logic [7:0]               ctrl1_q;
  logic [7:0]               ctrl2_q;
  adc_sweep_pkg::seq_state_t st_q;
  adc_sweep_pkg::seq_state_t st_d;
  logic [2:0]               pos_q;
  logic [2:0]               pos_d;
  logic [2:0]               other_q;
  logic [2:0]               other_d;
  logic [1:0]               prio_q;
  logic [1:0]               prio_d;
  logic                     phase_q;
  logic                     phase_d;
  logic                     clear_q;
  logic                     trig_prev_q;
  logic                     ack_q;
  logic [31:0]              dat_q;
  logic                     irq_q;
  logic [9:0]               result_q [8];

  conv_timer_if tm ();

  conv_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tm       (tm)
  );

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req_w = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_w  = req_w && wb_we_i && wb_sel_i[0];
  wire wr0_w = wr_w && (wb_adr_i == adc_sweep_pkg::OFS_CTRL0);
  wire wr1_w = wr_w && (wb_adr_i == adc_sweep_pkg::OFS_CTRL1);
  wire wr2_w = wr_w && (wb_adr_i == adc_sweep_pkg::OFS_CTRL2);

  // control field views
  wire                        start_w    = ctrl0_q[adc_sweep_pkg::C0_START];
  wire                        trig_sel_w = ctrl0_q[adc_sweep_pkg::C0_TRIG];
  wire                        trig_new_w = wb_dat_i[adc_sweep_pkg::C0_TRIG];
  wire adc_sweep_pkg::op_mode_t mode_w   =
    adc_sweep_pkg::op_mode_t'(ctrl0_q[adc_sweep_pkg::C0_MODE_LSB +: 2]);
  wire [1:0] width_w  = ctrl1_q[adc_sweep_pkg::C1_WIDTH_LSB +: 2];
  wire       ref_w    = ctrl1_q[adc_sweep_pkg::C1_REF];
  wire       ten_w    = ctrl1_q[adc_sweep_pkg::C1_TEN_BIT];
  wire adc_sweep_pkg::opamp_route_t route_w =
    adc_sweep_pkg::opamp_route_t'(ctrl1_q[adc_sweep_pkg::C1_OPAMP_LSB +: 2]);
  wire       is_sweep_w = mode_w[1];
  wire       rep_sw_w   = (mode_w == adc_sweep_pkg::MODE_REPEAT_SWEEP);
  wire       sweep1_w   = rep_sw_w && ctrl1_q[adc_sweep_pkg::C1_SWEEP1];
  wire       busy_w     = (st_q != adc_sweep_pkg::ST_IDLE);
  wire [2:0] div_sel_w  = {ctrl2_q[adc_sweep_pkg::C2_DIV2],
                           ctrl1_q[adc_sweep_pkg::C1_DIV1],
                           ctrl0_q[adc_sweep_pkg::C0_DIV0]};

  // start, halt and trigger events
  wire start_set_w = wr0_w && wb_dat_i[adc_sweep_pkg::C0_START]
                     && ref_w;                              // see R20
  wire halt_w      = wr0_w && !wb_dat_i[adc_sweep_pkg::C0_START]; // see R04
  wire begin_w     = start_set_w && !start_w;
  wire fall_w      = trig_prev_q && !external_trigger_pin
                     && trig_sel_w && start_w;              // see R03
  wire init_w      = !halt_w && (fall_w ||
                     (st_q == adc_sweep_pkg::ST_IDLE && begin_w
                      && !trig_new_w));                     // see R02
  wire done_ok_w   = tm.done && !clear_q
                     && (st_q == adc_sweep_pkg::ST_CONVERT);

  // pin selection and result slot
  wire [2:0] last_w    = {width_w, 1'b1};                    // see R06
  wire [2:0] seq_pin_w = sweep1_w ? (phase_q ? {1'b0, prio_q} : other_q)
                                  : pos_q;                   // see R08
  wire [2:0] pin_w     = is_sweep_w ? seq_pin_w
                         : ctrl0_q[adc_sweep_pkg::C0_CHAN_LSB +: 3];
  wire       ext_w     = !is_sweep_w &&
                         (route_w == adc_sweep_pkg::ROUTE_EXT_A ||
                          route_w == adc_sweep_pkg::ROUTE_EXT_B);
  wire [2:0] slot_w    = ext_w ? {2'b00, route_w == adc_sweep_pkg::ROUTE_EXT_B}
                               : pin_w;                      // see R17
  wire [9:0] code_w    = ten_w ? afe_code : {2'b00, afe_code[7:0]};
  wire       finish_w  = done_ok_w &&
                         (mode_w == adc_sweep_pkg::MODE_ONE_SHOT ||
                          (mode_w == adc_sweep_pkg::MODE_SINGLE_SWEEP &&
                           pos_q == last_w));                // see R01
  wire       start_d_w = halt_w ? 1'b0 : start_set_w ? 1'b1
                         : (finish_w && !trig_sel_w) ? 1'b0   // see R04
                         : start_w;                           // see R22

  // read data selection
  wire [5:0]  status_w = {(st_q == adc_sweep_pkg::ST_WAIT_TRIG), pin_w,
                          (st_q == adc_sweep_pkg::ST_CONVERT), busy_w};
  wire        res_hit_w = (wb_adr_i[7:5] == adc_sweep_pkg::OFS_RESULT[7:5])
                          && (wb_adr_i[1:0] == 2'b00);
  wire [31:0] rd_w =
    (wb_adr_i == adc_sweep_pkg::OFS_CTRL0)  ? {24'h000000, ctrl0_q} :
    (wb_adr_i == adc_sweep_pkg::OFS_CTRL1)  ? {24'h000000, ctrl1_q} :
    (wb_adr_i == adc_sweep_pkg::OFS_CTRL2)  ? {24'h000000, ctrl2_q} :
    (wb_adr_i == adc_sweep_pkg::OFS_STATUS) ? {26'h0000000, status_w} :
    res_hit_w ? {22'h000000, result_q[wb_adr_i[4:2]]} : 32'h00000000;

  // timer hookup
  assign tm.div_sel = div_sel_w;                              // see R19
  assign tm.sh_en   = ctrl2_q[adc_sweep_pkg::C2_SH];           // see R14
  assign tm.ten_bit = ten_w;
  assign tm.go      = (st_q == adc_sweep_pkg::ST_CONVERT);
  assign tm.clear   = clear_q;

  //////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_d    = st_q;
    pos_d   = pos_q;
    phase_d = phase_q;
    prio_d  = prio_q;
    other_d = other_q;
    if (halt_w) begin
      st_d = adc_sweep_pkg::ST_IDLE;
    end else if (init_w) begin
      st_d    = adc_sweep_pkg::ST_CONVERT;
      pos_d   = 3'h0;
      phase_d = 1'b1;
      prio_d  = 2'h0;
      other_d = adc_sweep_pkg::first_other(width_w);
    end else if (st_q == adc_sweep_pkg::ST_IDLE && begin_w) begin
      st_d = adc_sweep_pkg::ST_WAIT_TRIG;
    end else if (done_ok_w) begin
      if (finish_w) begin
        st_d = trig_sel_w ? adc_sweep_pkg::ST_WAIT_TRIG
                          : adc_sweep_pkg::ST_IDLE;           // see R04
      end else if (sweep1_w) begin
        if (phase_q) begin
          if (prio_q == width_w) begin                        // see R09
            phase_d = 1'b0;
          end else begin
            prio_d = prio_q + 2'h1;
          end
        end else begin
          phase_d = 1'b1;
          prio_d  = 2'h0;
          other_d = (other_q == 3'h7) ? adc_sweep_pkg::first_other(width_w)
                                      : other_q + 3'h1;       // see R08
        end
      end else if (pos_q == last_w) begin
        pos_d = 3'h0;                                         // see R07
      end else begin
        pos_d = pos_q + 3'h1;                                 // see R21
      end
    end
  end

  // sequencer and control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q        <= adc_sweep_pkg::ST_IDLE;
      pos_q       <= 3'h0;
      phase_q     <= 1'b1;
      prio_q      <= 2'h0;
      other_q     <= 3'h1;
      clear_q     <= 1'b0;
      trig_prev_q <= 1'b1;
      ctrl0_q     <= adc_sweep_pkg::CTRL0_RST;
      ctrl1_q     <= adc_sweep_pkg::CTRL1_RST;
      ctrl2_q     <= adc_sweep_pkg::CTRL2_RST;
    end else begin
      st_q        <= st_d;
      pos_q       <= pos_d;
      phase_q     <= phase_d;
      prio_q      <= prio_d;
      other_q     <= other_d;
      clear_q     <= init_w;
      trig_prev_q <= external_trigger_pin;
      if (wr0_w) begin
        ctrl0_q <= wb_dat_i[7:0];
      end
      ctrl0_q[adc_sweep_pkg::C0_START] <= start_d_w;
      if (wr1_w) begin
        ctrl1_q <= wb_dat_i[7:0];
        ctrl1_q[adc_sweep_pkg::C1_REF] <= wb_dat_i[adc_sweep_pkg::C1_REF]
                                          || (busy_w && ref_w); // see R20
      end
      if (wr2_w) begin
        ctrl2_q <= wb_dat_i[7:0] & adc_sweep_pkg::CTRL2_MASK;
      end
    end
  end

  // result store, one slot per pin position
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        result_q[i] <= 10'h000;
      end
    end else if (done_ok_w) begin
      result_q[slot_w] <= code_w;                             // see R10 R12
    end
  end

  // bus answer, interrupt request and front-end lines
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q           <= 1'b0;
      dat_q           <= 32'h00000000;
      irq_q           <= 1'b0;
      afe_group       <= 2'h0;
      afe_channel     <= 3'h0;
      afe_route       <= 2'h0;
      afe_ten_bit     <= 1'b0;
      afe_sample_hold <= 1'b0;
      afe_ref_connect <= 1'b0;
      afe_active      <= 1'b0;
    end else begin
      ack_q           <= req_w;
      if (req_w) begin
        dat_q <= rd_w;
      end
      irq_q           <= finish_w;                            // see R05
      afe_group       <= ctrl2_q[adc_sweep_pkg::C2_GROUP_LSB +: 2]; // see R11
      afe_channel     <= pin_w;
      afe_route       <= route_w;                             // see R18
      afe_ten_bit     <= ten_w;
      afe_sample_hold <= ctrl2_q[adc_sweep_pkg::C2_SH];
      afe_ref_connect <= ref_w;
      afe_active      <= (st_q == adc_sweep_pkg::ST_CONVERT);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign conv_irq = irq_q;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_sweep_bound;
    (st_q == adc_sweep_pkg::ST_CONVERT && !sweep1_w) |-> pos_q <= last_w;
  endproperty
  a_sweep_bound: assert property (p_sweep_bound) // see R06
    else $error("sweep position beyond selected width");

  property p_single_end;
    (finish_w && !trig_sel_w && !start_set_w) |=>
      (st_q == adc_sweep_pkg::ST_IDLE && !start_w);
  endproperty
  a_single_end: assert property (p_single_end) // see R01 R04
    else $error("soft-triggered sweep did not stop and clear start");

  property p_soft_start;
    (st_q == adc_sweep_pkg::ST_IDLE && begin_w && !trig_new_w) |=>
      (st_q == adc_sweep_pkg::ST_CONVERT && pos_q == 3'h0 && tm.clear)
      ##1 !tm.clear;
  endproperty
  a_soft_start: assert property (p_soft_start) // see R02
    else $error("software start did not begin conversion");

  property p_ext_wait;
    (st_q == adc_sweep_pkg::ST_WAIT_TRIG && !halt_w) |=>
      (st_q == adc_sweep_pkg::ST_CONVERT) == $past(fall_w);
  endproperty
  a_ext_wait: assert property (p_ext_wait) // see R03
    else $error("external trigger start mismatch");

  property p_irq_cause;
    conv_irq |-> $past(finish_w) && !$past(rep_sw_w);
  endproperty
  a_irq_cause: assert property (p_irq_cause) // see R05
    else $error("interrupt request without single sweep end");

  property p_rep0_wrap;
    (rep_sw_w && !sweep1_w && done_ok_w && pos_q == last_w
     && !halt_w && !fall_w) |=>
      (pos_q == 3'h0 && st_q == adc_sweep_pkg::ST_CONVERT && start_w);
  endproperty
  a_rep0_wrap: assert property (p_rep0_wrap) // see R07 R22
    else $error("repeat sweep 0 did not wrap to first pin");

  property p_prio_return;
    (sweep1_w && done_ok_w && !phase_q && !halt_w && !fall_w) |=>
      (phase_q && prio_q == 2'h0);
  endproperty
  a_prio_return: assert property (p_prio_return) // see R08
    else $error("priority pin not interleaved after other pin");

  property p_result_slot;
    done_ok_w |=> result_q[$past(slot_w)] == $past(code_w);
  endproperty
  a_result_slot: assert property (p_result_slot) // see R10
    else $error("result not stored in pin slot");

  property p_ref_gate;
    (wr0_w && !ref_w && !start_w) |=> !start_w;
  endproperty
  a_ref_gate: assert property (p_ref_gate) // see R20
    else $error("start accepted without reference connected");

endmodule

// ==== afe_model.sv ====
module afe_model (
  input  wire logic [1:0] afe_group,
  input  wire logic [2:0] afe_channel,
  input  wire logic [1:0] afe_route,
  input  wire logic [9:0] salt,
  output logic      [9:0] afe_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] src;

  // extended pins answer as a fourth group; the loop returns the pin
  assign src = (afe_route == 2'b01) ? 5'h18 :
               (afe_route == 2'b10) ? 5'h19 :
               {afe_group, afe_channel};
  assign afe_code = {src, 5'h00} ^ salt;
endmodule

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, cyc, stb, we, trig, irq, ack, active;
  logic        act_d, tb, ten, sh, refc;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, q;
  logic [9:0]  code, salt;
  logic [1:0]  grp, route, rt, w, g;
  logic [2:0]  ch, ch_d, s;
  int          n_errors, check_count, cyc_n, irq_n, seed, k, n, e, d;
  int          chs[$], tms[$];

  adc_sweep_sequencer uut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .external_trigger_pin(trig),
    .afe_code(code), .conv_irq(irq), .afe_group(grp), .afe_channel(ch),
    .afe_route(route), .afe_ten_bit(ten), .afe_sample_hold(sh),
    .afe_ref_connect(refc), .afe_active(active)
  );
  afe_model far (
    .afe_group(grp), .afe_channel(ch), .afe_route(route), .salt(salt),
    .afe_code(code)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // pin log, interrupt count and hang guard
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    act_d <= active;
    ch_d <= ch;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (active === 1'b1 && (act_d !== 1'b1 || ch !== ch_d)) begin
      chs.push_back(ch);
      tms.push_back(cyc_n);
    end
    if (cyc_n == 40000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [31:0] v);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= v;
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wirq;
    k = irq_n;
    do @(posedge core_clk); while (irq_n == k);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic start(input logic [7:0] c0);
    chs.delete();
    tms.delete();
    salt <= 10'($random(seed));
    wb(1'b1, adc_sweep_pkg::OFS_CTRL0, {24'h0, c0});
  endtask
  // drop a stale pin seen as the sweep came up
  task automatic trim;
    if (chs.size() > 0 && chs[0] != 0) begin
      void'(chs.pop_front());
      void'(tms.pop_front());
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_res(input logic [4:0] p,
                                          input logic t);
    logic [9:0] c;
    c = {p, 5'h00} ^ salt;
    exp_res = t ? {22'h0, c} : {24'h0, c[7:0]};
  endfunction
  function automatic int ratio(input logic [2:0] v);
    case (v)
      3'h0: ratio = 4;
      3'h1: ratio = 2;
      3'h4: ratio = 12;
      3'h5: ratio = 6;
      3'h6, 3'h7: ratio = 3;
      default: ratio = 1;
    endcase
  endfunction
  function automatic int pri(input int i, input int x);
    pri = i % (x + 2);
    if (pri > x) pri = x + 1 + (i / (x + 2)) % (7 - x);
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, dat, salt} = '0;
    {cyc_n, irq_n, n_errors, check_count} = '0;
    trig = 1'b1;
    rst = 1'b1;
    seed = 32'h8dee482d;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 20; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk(q, 32'h0);
    end
    start(8'h50);
    wb(1'b0, adc_sweep_pkg::OFS_CTRL0, 32'h0);
    chk(q[6], 1'b0);
    chk(active, 1'b0);
    wb(1'b1, adc_sweep_pkg::OFS_CTRL1, 32'h20);
    repeat (260) @(posedge core_clk);
    $display("test reset and refusal done");
    // single sweeps over widths, groups, dividers and resolutions
    for (int i = 0; i < 12; i++) begin
      w = 2'(i);
      s = 3'(i);
      g = 2'(i / 4);
      tb = 1'($random(seed));
      rt = {2{1'($random(seed))}};
      wb(1'b1, adc_sweep_pkg::OFS_CTRL2, {28'h0, s[2], g, 1'b1});
      wb(1'b1, adc_sweep_pkg::OFS_CTRL1, {24'h0, rt, 1'b1, s[1], tb, 1'b0, w});
      start({s[0], 7'h50});
      wirq();
      chk(irq_n - k, 1);
      chk(route, rt);
      chk(ten, tb);
      chk(sh, 1'b1);
      chk(refc, 1'b1);
      chk(grp, g);
      wb(1'b0, adc_sweep_pkg::OFS_CTRL0, 32'h0);
      chk(q[6], 1'b0);
      n = 2 * w + 2;
      trim();
      chk(chs.size() >= n, 1'b1);
      for (int p = 0; p < n; p++) chk(chs[p], p);
      e = ratio(s) * (tb ? 33 : 28);
      d = tms[1] - tms[0];
      chk(d >= e && d <= e + 3, 1'b1);
      for (int p = 0; p < n; p++) begin
        wb(1'b0, adc_sweep_pkg::OFS_RESULT + 8'(4 * p), 32'h0);
        chk(q, exp_res({g, 3'(p)}, tb));
      end
    end
    $display("test single sweep done");
    // repeat sweep 0 loops four pins of group 2 without interrupts
    wb(1'b1, adc_sweep_pkg::OFS_CTRL2, 32'h5);
    wb(1'b1, adc_sweep_pkg::OFS_CTRL1, 32'h31);
    k = irq_n;
    start(8'h58);
    repeat (300) @(posedge core_clk);
    chk(irq_n, k);
    wb(1'b0, adc_sweep_pkg::OFS_CTRL0, 32'h0);
    chk(q[6], 1'b1);
    trim();
    for (int p = 0; p < 8; p++) chk(chs[p], p % 4);
    wb(1'b1, adc_sweep_pkg::OFS_CTRL0, 32'h18);
    repeat (4) @(posedge core_clk);
    chk(active, 1'b0);
    $display("test repeat sweep 0 done");
    // repeat sweep 1 interleaves the priority pins
    w = 2'($random(seed));
    wb(1'b1, adc_sweep_pkg::OFS_CTRL1, {24'h0, 6'h0d, w});
    start(8'h58);
    repeat (500) @(posedge core_clk);
    trim();
    for (int p = 0; p < 12; p++) chk(chs[p], pri(p, w));
    wb(1'b1, adc_sweep_pkg::OFS_CTRL0, 32'h18);
    $display("test repeat sweep 1 done");
    // falling trigger pin starts a sweep and restarts it when repeated
    wb(1'b1, adc_sweep_pkg::OFS_CTRL1, 32'h31);
    wb(1'b1, adc_sweep_pkg::OFS_CTRL2, 32'h1);
    start(8'h70);
    repeat (50) @(posedge core_clk);
    chk(active, 1'b0);
    trig <= 1'b0;
    repeat (45) @(posedge core_clk);
    trig <= 1'b1;
    @(posedge core_clk);
    trig <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(ch, 3'h0);
    wirq();
    wb(1'b0, adc_sweep_pkg::OFS_CTRL0, 32'h0);
    chk(q[6], 1'b1);
    wb(1'b1, adc_sweep_pkg::OFS_CTRL0, 32'h10);
    trig <= 1'b1;
    $display("test external trigger done");
    // one-shot on each extended pin
    for (int r = 1; r < 3; r++) begin
      wb(1'b1, adc_sweep_pkg::OFS_CTRL1, {24'h0, 2'(r), 6'h30});
      start(8'h40);
      wirq();
      wb(1'b0, adc_sweep_pkg::OFS_RESULT + 8'(4 * (r - 1)), 32'h0);
      chk(q, exp_res(5'(23 + r), 1'b0));
    end
    // repeat mode keeps converting the second extended pin, no interrupt
    k = irq_n;
    start(8'h48);
    repeat (100) @(posedge core_clk);
    chk(irq_n, k);
    chk(active, 1'b1);
    wb(1'b0, adc_sweep_pkg::OFS_RESULT + 8'h04, 32'h0);
    chk(q, exp_res(5'h19, 1'b0));
    wb(1'b1, adc_sweep_pkg::OFS_CTRL0, 32'h08);
    repeat (4) @(posedge core_clk);
    chk(active, 1'b0);
    $display("test extended pins done");
    wrap_up();
  end
endmodule
